// >>> src/bsc_pkg.sv
package bsc_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_BUS = 2;
  localparam int NUM_FLAGS = 6;
  localparam int IRQ_W = NUM_BUS * NUM_FLAGS;
  localparam int ADDR_W = 10;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_BUS_NUMS = 10'h018;
  localparam logic [ADDR_W-1:0] OFF_IO_STAT = 10'h01c;
  localparam logic [ADDR_W-1:0] OFF_IO_UPPER = 10'h030;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 10'h040;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 10'h200;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 10'h204;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 10'h208;
  localparam int FUNC_SEL_BIT = 8;

  // ==========================================================
  // field positions
  localparam int SUB_BUS_LSB = 16;
  localparam int LAT_LSB = 24;
  localparam int IO_IND_BASE_LSB = 0;
  localparam int IO_BASE_LSB = 4;
  localparam int IO_IND_LIM_LSB = 8;
  localparam int IO_LIMIT_LSB = 12;
  localparam int UP_BASE_LSB = 0;
  localparam int UP_LIMIT_LSB = 16;
  localparam int CTRL_PERR_EN = 0;
  localparam int STS_66MHZ = 21;
  localparam int STS_FBB = 23;
  localparam int STS_PERR = 24;
  localparam int STS_DEVSEL_LSB = 25;
  localparam int STS_STA = 27;
  localparam int STS_RTA = 28;
  localparam int STS_RMA = 29;
  localparam int STS_SSE = 30;
  localparam int STS_DPE = 31;

  // flag index inside the per-bus sticky vector
  localparam int FLG_PERR = 0;
  localparam int FLG_STA = 1;
  localparam int FLG_RTA = 2;
  localparam int FLG_RMA = 3;
  localparam int FLG_SSE = 4;
  localparam int FLG_DPE = 5;

  // ==========================================================
  // fixed and reset values
  localparam logic [3:0] IO_32BIT_IND = 4'h1;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic STS_66MHZ_VAL = 1'b1;
  localparam logic STS_FBB_VAL = 1'b0;
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] subBus;
    logic [7:0] latTimer;
    logic [3:0] ioBase;
    logic [3:0] ioLimit;
    logic [15:0] ioBaseUp;
    logic [15:0] ioLimitUp;
    logic perrEn;
    logic [NUM_FLAGS-1:0] flags;
    logic latRun;
    logic [7:0] latCnt;
  } bsc_bus_t;

endpackage : bsc_pkg

// >>> src/bsc_io_window.sv
`timescale 1ns/1ps
module bsc_io_window
  import bsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ioValid,
  input wire logic [31:0] ioAddr,
  input wire logic [15:0] baseUp,
  input wire logic [3:0] baseNib,
  input wire logic [15:0] limitUp,
  input wire logic [3:0] limitNib,
  output logic ioForward
);

  typedef struct packed {
    logic fwd;
  } bsc_win_state_t;

  bsc_win_state_t s_r;
  bsc_win_state_t s_nxt;
  logic [31:0] winBottom;
  logic [31:0] winTop;

  // ==========================================================
  // window bounds and compare
  assign winBottom = {baseUp, baseNib, IO_LOW_ZERO};
  assign winTop = {limitUp, limitNib, IO_LOW_ONES};

  always_comb begin
    s_nxt = s_r;
    s_nxt.fwd = ioValid && (ioAddr >= winBottom) && (ioAddr <= winTop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ioForward = s_r.fwd;

endmodule : bsc_io_window

// >>> src/bsc_top.sv
// Summary of operation
// - each of the two downstream buses owns its own copy of all fields.
// - bits 23:16 hold highest bus number behind bridge, writable, reset 0.
// - bits 31:24 hold the downstream latency timer in bus clocks, reset 0.
// - latency timer supervises unclaimed master cycles on each downstream bus.
// - io base bits 3:0 and limit bits 11:8 read 1 for 32-bit io.
// - io base bits 7:4 give window bottom 15:12, low bits zero.
// - io limit bits 15:12 give window top 15:12, low bits all ones.
// - window address bits 31:16 come from the separate upper io register.
// - io addresses inside base..limit are forwarded across the bridge.
// - status bit 21 reads 1: the bus can run at 66 MHz.
// - status bit 23, fast back-to-back capability, reads 0.
// - bit 24 sets on parity pin assert while parity response is enabled.
// - bits 26:25 read 01, medium device-select timing.
// - bit 27 sets when this device ends a cycle with target abort.
// - bit 28 sets when our master cycle is target aborted.
// - bit 29 sets when our master cycle ends with master abort.
// - bit 30 sets when the bus system error pin is asserted.
// - bit 31 sets on detected address or data parity error.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module bsc_top
  import bsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic firstDownstreamParityErrorPinN,
  input wire logic secondDownstreamParityErrorPinN,
  input wire logic firstDownstreamSystemErrorPinN,
  input wire logic secondDownstreamSystemErrorPinN,
  input wire logic [NUM_BUS-1:0] parityErrDetected,
  input wire logic [NUM_BUS-1:0] targetAbortSent,
  input wire logic [NUM_BUS-1:0] targetAbortRcvd,
  input wire logic [NUM_BUS-1:0] masterAbortRcvd,
  input wire logic [NUM_BUS-1:0] masterStart,
  input wire logic [NUM_BUS-1:0] masterClaimed,
  input wire logic [NUM_BUS-1:0] ioValid,
  input wire logic [31:0] ioAddr,
  output logic [NUM_BUS-1:0] ioForward,
  output logic [NUM_BUS-1:0] latencyExpired,
  output logic irq
);

  typedef struct packed {
    bsc_bus_t [NUM_BUS-1:0] bus;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    logic [31:0] rdData;
  } bsc_top_state_t;

  bsc_top_state_t s_r;
  bsc_top_state_t s_nxt;
  logic [1:0] rstSync_r;
  logic rst_n;
  logic [NUM_BUS-1:0] perrPinN;
  logic [NUM_BUS-1:0] serrPinN;
  logic [NUM_BUS-1:0] latExpire;
  logic [NUM_FLAGS-1:0] evt [NUM_BUS];
  logic [IRQ_W-1:0] evtAll;
  logic [ADDR_W-1:0] localAddr;
  logic fnSel;

  // ==========================================================
  // reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rst_n = rstSync_r[1];

  // ==========================================================
  // status word of one bus
  function automatic logic [31:0] stsWord(input bsc_bus_t x);
    logic [31:0] w;
    w = RD_ZERO;
    w[IO_IND_BASE_LSB +: 4] = IO_32BIT_IND;
    w[IO_BASE_LSB +: 4] = x.ioBase;
    w[IO_IND_LIM_LSB +: 4] = IO_32BIT_IND;
    w[IO_LIMIT_LSB +: 4] = x.ioLimit;
    w[STS_66MHZ] = STS_66MHZ_VAL;
    w[STS_FBB] = STS_FBB_VAL;
    w[STS_PERR] = x.flags[FLG_PERR];
    w[STS_DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
    w[STS_STA] = x.flags[FLG_STA];
    w[STS_RTA] = x.flags[FLG_RTA];
    w[STS_RMA] = x.flags[FLG_RMA];
    w[STS_SSE] = x.flags[FLG_SSE];
    w[STS_DPE] = x.flags[FLG_DPE];
    return w;
  endfunction : stsWord

  function automatic logic [NUM_FLAGS-1:0] clrMask(input logic [31:0] d);
    logic [NUM_FLAGS-1:0] m;
    m = '0;
    m[FLG_PERR] = d[STS_PERR];
    m[FLG_STA] = d[STS_STA];
    m[FLG_RTA] = d[STS_RTA];
    m[FLG_RMA] = d[STS_RMA];
    m[FLG_SSE] = d[STS_SSE];
    m[FLG_DPE] = d[STS_DPE];
    return m;
  endfunction : clrMask

  // ==========================================================
  // per-bus events and io window
  assign perrPinN = {secondDownstreamParityErrorPinN,
                     firstDownstreamParityErrorPinN};
  assign serrPinN = {secondDownstreamSystemErrorPinN,
                     firstDownstreamSystemErrorPinN};

  genvar g;
  generate
    for (g = 0; g < NUM_BUS; g++) begin : gBus
      // unclaimed master cycle ran out its latency budget
      assign latExpire[g] = s_r.bus[g].latRun && !masterStart[g] &&
        !masterClaimed[g] &&
        (s_r.bus[g].latCnt == s_r.bus[g].latTimer);
      assign evt[g][FLG_PERR] = !perrPinN[g] && s_r.bus[g].perrEn;
      assign evt[g][FLG_STA] = targetAbortSent[g];
      assign evt[g][FLG_RTA] = targetAbortRcvd[g];
      assign evt[g][FLG_RMA] = masterAbortRcvd[g] || latExpire[g];
      assign evt[g][FLG_SSE] = !serrPinN[g];
      assign evt[g][FLG_DPE] = parityErrDetected[g];
      assign evtAll[g*NUM_FLAGS +: NUM_FLAGS] = evt[g];

      bsc_io_window uWin (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ioValid(ioValid[g]),
        .ioAddr(ioAddr),
        .baseUp(s_r.bus[g].ioBaseUp),
        .baseNib(s_r.bus[g].ioBase),
        .limitUp(s_r.bus[g].ioLimitUp),
        .limitNib(s_r.bus[g].ioLimit),
        .ioForward(ioForward[g])
      );

      // ========================================================
      // checks per bus
      property p_sub_bus_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        regWr && fnSel == 1'(g) && localAddr == OFF_BUS_NUMS |=>
          s_r.bus[g].subBus == $past(regWrData[SUB_BUS_LSB +: 8]);
      endproperty
      a_sub_bus_wr: assert property (p_sub_bus_wr)
        else $error("bus number field not written");

      property p_lat_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        regWr && fnSel == 1'(g) && localAddr == OFF_BUS_NUMS |=>
          s_r.bus[g].latTimer == $past(regWrData[LAT_LSB +: 8]);
      endproperty
      a_lat_wr: assert property (p_lat_wr)
        else $error("latency timer not written");

      property p_lat_expire;
        @(posedge clk_sys) disable iff (!rst_n)
        masterStart[g] ##1 (!masterStart[g] && !masterClaimed[g])
          [*1] ##0 (s_r.bus[g].latTimer == 8'h00) |->
          latencyExpired[g] ##1 s_r.bus[g].flags[FLG_RMA];
      endproperty
      a_lat_expire: assert property (p_lat_expire)
        else $error("zero latency timer did not expire");

      property p_io_bottom;
        @(posedge clk_sys) disable iff (!rst_n)
        ioValid[g] && ioAddr == {s_r.bus[g].ioBaseUp, s_r.bus[g].ioBase,
          IO_LOW_ZERO} && {s_r.bus[g].ioBaseUp, s_r.bus[g].ioBase} <=
          {s_r.bus[g].ioLimitUp, s_r.bus[g].ioLimit} |=> ioForward[g];
      endproperty
      a_io_bottom: assert property (p_io_bottom)
        else $error("window bottom not forwarded");

      property p_io_above;
        @(posedge clk_sys) disable iff (!rst_n)
        ioValid[g] && ioAddr > {s_r.bus[g].ioLimitUp, s_r.bus[g].ioLimit,
          IO_LOW_ONES} |=> !ioForward[g];
      endproperty
      a_io_above: assert property (p_io_above)
        else $error("address above window forwarded");

      property p_perr_set;
        @(posedge clk_sys) disable iff (!rst_n)
        !perrPinN[g] && s_r.bus[g].perrEn |=> s_r.bus[g].flags[FLG_PERR];
      endproperty
      a_perr_set: assert property (p_perr_set)
        else $error("parity pin flag not set");

      property p_perr_gated;
        @(posedge clk_sys) disable iff (!rst_n)
        !s_r.bus[g].perrEn && !s_r.bus[g].flags[FLG_PERR] |=>
          !s_r.bus[g].flags[FLG_PERR];
      endproperty
      a_perr_gated: assert property (p_perr_gated)
        else $error("parity flag set while response disabled");

      property p_flag_set;
        @(posedge clk_sys) disable iff (!rst_n)
        targetAbortSent[g] || !serrPinN[g] |=>
          s_r.bus[g].flags[FLG_STA] || s_r.bus[g].flags[FLG_SSE];
      endproperty
      a_flag_set: assert property (p_flag_set)
        else $error("event flag not set");

      property p_w1c;
        @(posedge clk_sys) disable iff (!rst_n)
        regWr && fnSel == 1'(g) && localAddr == OFF_IO_STAT &&
          regWrData[STS_DPE] && !parityErrDetected[g] |=>
          !s_r.bus[g].flags[FLG_DPE];
      endproperty
      a_w1c: assert property (p_w1c)
        else $error("write one did not clear flag");
    end
  endgenerate

  // ==========================================================
  // register decode
  assign fnSel = regAddr[FUNC_SEL_BIT];
  always_comb begin
    localAddr = regAddr;
    localAddr[FUNC_SEL_BIT] = 1'b0;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = RD_ZERO;
    for (int b = 0; b < NUM_BUS; b++) begin
      if (regWr && fnSel == b[0]) begin
        unique case (localAddr)
          OFF_BUS_NUMS: begin
            s_nxt.bus[b].subBus = regWrData[SUB_BUS_LSB +: 8];
            s_nxt.bus[b].latTimer = regWrData[LAT_LSB +: 8];
          end
          OFF_IO_STAT: begin
            s_nxt.bus[b].ioBase = regWrData[IO_BASE_LSB +: 4];
            s_nxt.bus[b].ioLimit = regWrData[IO_LIMIT_LSB +: 4];
            s_nxt.bus[b].flags = s_r.bus[b].flags &
              ~clrMask(regWrData);
          end
          OFF_IO_UPPER: begin
            s_nxt.bus[b].ioBaseUp = regWrData[UP_BASE_LSB +: 16];
            s_nxt.bus[b].ioLimitUp = regWrData[UP_LIMIT_LSB +: 16];
          end
          OFF_CTRL: begin
            s_nxt.bus[b].perrEn = regWrData[CTRL_PERR_EN];
          end
          default: begin
          end
        endcase
      end
      // set wins over a same-cycle clear
      s_nxt.bus[b].flags = s_nxt.bus[b].flags | evt[b];
      // latency supervision of master cycles
      if (masterStart[b]) begin
        s_nxt.bus[b].latRun = 1'b1;
        s_nxt.bus[b].latCnt = RST_BYTE;
      end else if (s_r.bus[b].latRun) begin
        if (masterClaimed[b] || latExpire[b]) begin
          s_nxt.bus[b].latRun = 1'b0;
        end else begin
          s_nxt.bus[b].latCnt = s_r.bus[b].latCnt + 8'h01;
        end
      end
    end
    // interrupt status and enable
    if (regWr && regAddr == OFF_IRQ_CLR) begin
      s_nxt.irqStat = s_r.irqStat & ~regWrData[IRQ_W-1:0];
    end
    if (regWr && regAddr == OFF_IRQ_EN) begin
      s_nxt.irqEn = regWrData[IRQ_W-1:0];
    end
    s_nxt.irqStat = s_nxt.irqStat | evtAll;
    // read data, valid in the following cycle only
    if (regRd) begin
      if (regAddr == OFF_IRQ_STAT) begin
        s_nxt.rdData = {{(32-IRQ_W){1'b0}}, s_r.irqStat};
      end else if (regAddr == OFF_IRQ_EN) begin
        s_nxt.rdData = {{(32-IRQ_W){1'b0}}, s_r.irqEn};
      end else begin
        for (int b = 0; b < NUM_BUS; b++) begin
          if (fnSel == b[0]) begin
            unique case (localAddr)
              OFF_BUS_NUMS: begin
                s_nxt.rdData[SUB_BUS_LSB +: 8] = s_r.bus[b].subBus;
                s_nxt.rdData[LAT_LSB +: 8] = s_r.bus[b].latTimer;
              end
              OFF_IO_STAT: begin
                s_nxt.rdData = stsWord(s_r.bus[b]);
              end
              OFF_IO_UPPER: begin
                s_nxt.rdData[UP_BASE_LSB +: 16] = s_r.bus[b].ioBaseUp;
                s_nxt.rdData[UP_LIMIT_LSB +: 16] = s_r.bus[b].ioLimitUp;
              end
              OFF_CTRL: begin
                s_nxt.rdData[CTRL_PERR_EN] = s_r.bus[b].perrEn;
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign regRdData = s_r.rdData;
  assign latencyExpired = latExpire;
  assign irq = |(s_r.irqStat & s_r.irqEn);

  // ==========================================================
  // global checks
  property p_fixed_bits;
    @(posedge clk_sys) disable iff (!rst_n)
    regRd && localAddr == OFF_IO_STAT |=>
      regRdData[STS_66MHZ] && !regRdData[STS_FBB] &&
      regRdData[STS_DEVSEL_LSB +: 2] == DEVSEL_MEDIUM &&
      regRdData[IO_IND_BASE_LSB +: 4] == IO_32BIT_IND &&
      regRdData[IO_IND_LIM_LSB +: 4] == IO_32BIT_IND &&
      regRdData[20:16] == 5'h00 && !regRdData[22];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed status bits read wrong");

  property p_rd_once;
    @(posedge clk_sys) disable iff (!rst_n)
    !regRd |=> regRdData == RD_ZERO;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data held beyond its cycle");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    evtAll[FLG_PERR] && s_r.irqEn[FLG_PERR] &&
      !(regWr && regAddr == OFF_IRQ_EN) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise interrupt");

endmodule : bsc_top

// >>> tb/bsc_agent_model.sv
`timescale 1ns/1ps
module bsc_agent_model
  import bsc_pkg::*;
(
  input wire logic clk_sys,
  output logic [NUM_BUS-1:0] perrPinN,
  output logic [NUM_BUS-1:0] serrPinN,
  output logic [NUM_BUS-1:0] parityErrDetected,
  output logic [NUM_BUS-1:0] targetAbortSent,
  output logic [NUM_BUS-1:0] targetAbortRcvd,
  output logic [NUM_BUS-1:0] masterAbortRcvd,
  output logic [NUM_BUS-1:0] masterStart,
  output logic [NUM_BUS-1:0] masterClaimed,
  output logic [NUM_BUS-1:0] ioValid,
  output logic [31:0] ioAddr
);
  // ==========================================================
  // idle state: error pins pulled up, no events
  initial begin
    perrPinN = '1;
    serrPinN = '1;
    parityErrDetected = '0;
    targetAbortSent = '0;
    targetAbortRcvd = '0;
    masterAbortRcvd = '0;
    masterStart = '0;
    masterClaimed = '0;
    ioValid = '0;
    ioAddr = 32'h0000_0000;
  end

  // ==========================================================
  // kinds 0..5 follow flag order, 6 start, 7 claim
  task automatic set(input int b, input int f, input logic v);
    case (f)
      FLG_PERR: perrPinN[b] <= ~v;
      FLG_STA: targetAbortSent[b] <= v;
      FLG_RTA: targetAbortRcvd[b] <= v;
      FLG_RMA: masterAbortRcvd[b] <= v;
      FLG_SSE: serrPinN[b] <= ~v;
      FLG_DPE: parityErrDetected[b] <= v;
      6: masterStart[b] <= v;
      default: masterClaimed[b] <= v;
    endcase
  endtask : set

  task automatic pulse(input int b, input int f);
    @(posedge clk_sys);
    set(b, f, 1'b1);
    @(posedge clk_sys);
    set(b, f, 1'b0);
  endtask : pulse

  // address line shows a changed pattern once released
  task automatic io(input int b, input logic [31:0] a);
    @(posedge clk_sys);
    ioValid[b] <= 1'b1;
    ioAddr <= a;
    @(posedge clk_sys);
    ioValid[b] <= 1'b0;
    ioAddr <= ~a;
  endtask : io
endmodule : bsc_agent_model

// >>> tb/bridge_secondary_config_regs_test.sv
`timescale 1ns/1ps
module bridge_secondary_config_regs_test
  import bsc_pkg::*;
;
  localparam logic [31:0] STS_FIXED = 32'h0220_0101;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData, ioAddr;
  logic [NUM_BUS-1:0] perrPinN, serrPinN, pErr, taSent, taRcvd, maRcvd;
  logic [NUM_BUS-1:0] mStart, mClaim, ioValid, ioForward, latencyExpired;
  logic irq;
  logic rdSeen = 1'b0;
  logic [31:0] expQ[$];
  int n_mismatch = 0;
  int checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  bsc_agent_model agent (.clk_sys(clk_sys), .perrPinN(perrPinN),
    .serrPinN(serrPinN), .parityErrDetected(pErr), .targetAbortSent(taSent),
    .targetAbortRcvd(taRcvd), .masterAbortRcvd(maRcvd),
    .masterStart(mStart), .masterClaimed(mClaim), .ioValid(ioValid),
    .ioAddr(ioAddr));

  bsc_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData),
    .firstDownstreamParityErrorPinN(perrPinN[0]),
    .secondDownstreamParityErrorPinN(perrPinN[1]),
    .firstDownstreamSystemErrorPinN(serrPinN[0]),
    .secondDownstreamSystemErrorPinN(serrPinN[1]),
    .parityErrDetected(pErr), .targetAbortSent(taSent),
    .targetAbortRcvd(taRcvd), .masterAbortRcvd(maRcvd),
    .masterStart(mStart), .masterClaimed(mClaim), .ioValid(ioValid),
    .ioAddr(ioAddr), .ioForward(ioForward),
    .latencyExpired(latencyExpired), .irq(irq));

  // ==========================================================
  // compare, verdict, register bus
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  function automatic logic [ADDR_W-1:0] adr(input int b,
                                            input logic [ADDR_W-1:0] a);
    return a | (ADDR_W'(b) << FUNC_SEL_BIT);
  endfunction : adr

  task automatic wr(input int b, input logic [ADDR_W-1:0] a,
                    input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= adr(b, a);
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input int b, input logic [ADDR_W-1:0] a,
                    input logic [31:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= adr(b, a);
    expQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rd

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdSeen) chk(regRdData, expQ.pop_front());
    rdSeen <= regRd;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  // ==========================================================
  // scenarios
  initial begin : main
    int n, k;
    logic seen;
    logic [3:0] lo, hi;
    logic [31:0] u;
    logic [31:0] d [NUM_BUS];
    logic [31:0] sb [NUM_BUS];
    logic [31:0] pa [5];
    int fb [NUM_FLAGS];
    fb = '{STS_PERR, STS_STA, STS_RTA, STS_RMA, STS_SSE, STS_DPE};
    void'($urandom(32'hadc5));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int b = 0; b < NUM_BUS; b++) begin
      rd(b, OFF_BUS_NUMS, 32'h0000_0000);
      rd(b, OFF_IO_STAT, STS_FIXED);
      d[b] = $urandom;
      wr(b, OFF_BUS_NUMS, d[b]);
    end
    for (int b = 0; b < NUM_BUS; b++) begin
      rd(b, OFF_BUS_NUMS, d[b] & 32'hffff_0000);
      wr(b, OFF_IO_STAT, ~d[b]);
      rd(b, OFF_IO_STAT, (~d[b] & 32'h0000_f0f0) | STS_FIXED);
    end
    rd(0, 10'h0f0, 32'h0000_0000);
    for (int b = 0; b < NUM_BUS; b++) begin
      u = $urandom;
      lo = 4'($urandom_range(7, 1));
      hi = 4'($urandom_range(14, 8));
      sb[b] = {16'h0000, hi, 4'h1, lo, 4'h1} | STS_FIXED;
      wr(b, OFF_IO_UPPER, {u[15:0], u[15:0]});
      rd(b, OFF_IO_UPPER, {u[15:0], u[15:0]});
      wr(b, OFF_IO_STAT, {16'h0000, hi, 4'h0, lo, 4'h0});
      rd(b, OFF_IO_STAT, sb[b]);
      pa[0] = {u[15:0], lo, 12'h000};
      pa[1] = pa[0] - 32'h0000_0001;
      pa[2] = {u[15:0], hi, 12'hfff};
      pa[3] = pa[2] + 32'h0000_0001;
      pa[4] = {u[15:0] + 16'h0001, lo, 12'h000};
      for (int i = 0; i < 5; i++) begin
        agent.io(b, pa[i]);
        #1 chk(32'(ioForward), (i == 0 || i == 2) ? 32'(1 << b) : 0);
      end
    end
    wr(0, OFF_IRQ_EN, 32'h0000_0fff);
    for (int b = 0; b < NUM_BUS; b++) begin
      agent.pulse(b, FLG_PERR);
      rd(b, OFF_IO_STAT, sb[b]);
      wr(b, OFF_CTRL, 32'h0000_0001);
      for (int f = 0; f < NUM_FLAGS; f++) begin
        agent.pulse(b, f);
        rd(b, OFF_IO_STAT, sb[b] | (32'h1 << fb[f]));
        rd(0, OFF_IRQ_STAT, 32'h1 << (b * NUM_FLAGS + f));
        chk(32'(irq), 32'h1);
        wr(b, OFF_IO_STAT, sb[b] | (32'h1 << fb[f]));
        wr(0, OFF_IRQ_CLR, 32'hffff_ffff);
        rd(b, OFF_IO_STAT, sb[b]);
        rd(0, OFF_IRQ_CLR, 32'h0000_0000);
        chk(32'(irq), 32'h0);
      end
    end
    wr(0, OFF_IRQ_EN, 32'h0000_0000);
    agent.pulse(1, FLG_DPE);
    rd(0, OFF_IRQ_STAT, 32'h0000_0800);
    chk(32'(irq), 32'h0);
    wr(0, OFF_IRQ_CLR, 32'h0000_0800);
    wr(1, OFF_IO_STAT, sb[1] | 32'h8000_0000);
    for (int b = 0; b < NUM_BUS; b++) begin
      n = $urandom_range(9, 2);
      wr(b, OFF_BUS_NUMS, 32'(n) << LAT_LSB);
      agent.pulse(b, 6);
      k = 0;
      while (latencyExpired[b] !== 1'b1 && k < 40) begin
        @(posedge clk_sys);
        k++;
      end
      chk(32'(k), 32'(n + 1));
      rd(b, OFF_IO_STAT, sb[b] | (32'h1 << STS_RMA));
      wr(b, OFF_IO_STAT, sb[b] | (32'h1 << STS_RMA));
      agent.pulse(b, 6);
      agent.pulse(b, 7);
      seen = 1'b0;
      repeat (14) begin
        @(posedge clk_sys);
        seen = seen | (latencyExpired[b] !== 1'b0);
      end
      chk(32'(seen), 32'h0);
    end
    // zero latency budget expires in the first cycle after the start
    wr(0, OFF_BUS_NUMS, 32'h0000_0000);
    agent.pulse(0, 6);
    rd(0, OFF_IO_STAT, sb[0] | (32'h1 << STS_RMA));
    repeat (3) @(posedge clk_sys);
    close_out();
  end : main
endmodule : bridge_secondary_config_regs_test
